// ==== rtl/preset_counter_setup_decode.sv ====
// setup selection, checking and register access of the preset counter
`timescale 1ns/1ps
`default_nettype none
`include "setup_cfg.svh"

module preset_counter_setup_decode #(
   parameter bit          SIX_DIGIT     = 1'b1,
   parameter logic [15:0] STYLE_MASK    = 16'h1ffe,
   parameter int unsigned RATE_SLOW_CYC =
      (`CLK_MHZ * 1000000 + `RATE_SLOW_HZ - 1) / `RATE_SLOW_HZ,
   parameter int unsigned RATE_FAST_CYC =
      (`CLK_MHZ * 1000000 + `RATE_FAST_HZ - 1) / `RATE_FAST_HZ,
   parameter int unsigned RST_LONG_CYC  = `RST_LONG_MS * `CLK_MHZ * 1000,
   parameter int unsigned RST_SHORT_CYC = `RST_SHORT_MS * `CLK_MHZ * 1000
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  dip_sw,
   input  wire logic [7:0]  awaddr,
   input  wire logic [2:0]  awprot,
   input  wire logic        awvalid,
   output var  logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output var  logic        wready,
   output var  logic [1:0]  bresp,
   output var  logic        bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic [2:0]  arprot,
   input  wire logic        arvalid,
   output var  logic        arready,
   output var  logic [31:0] rdata,
   output var  logic [1:0]  rresp,
   output var  logic        rvalid,
   input  wire logic        rready,
   output var  logic        switch_mode,
   output var  logic        count_rate_setting,
   output var  logic        count_bounce_filter,
   output var  logic [23:0] count_period_cyc,
   output var  logic [2:0]  count_dir,
   output var  logic [3:0]  out_style,
   output var  logic        oneshot_enable,
   output var  logic [13:0] pulse_time_cs,
   output var  logic        pulse_on_stage_two,
   output var  logic        stage_one_pulse_en,
   output var  logic [13:0] stage_one_time_cs,
   output var  logic        latched_indication,
   output var  logic [23:0] reset_width_cyc,
   output var  logic        reset_bounce_filter,
   output var  logic        input_sourcing,
   output var  logic [1:0]  stage_cfg,
   output var  logic        dual_sub
);

   ////////////////////////////////////////////////////////////////////////////
   // power-on capture of the switches

   logic [7:0]       sw_sync;
   logic [7:0]       sw_r;
   logic [1:0]       settle_r;
   setup_pkg::pwr_e  pwr_r;

   pin_sync #(
      .W       (8)
   ) u_sw_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .d       (dip_sw),
      .q       (sw_sync)
   );

   // one capture per reset; the sync pipe must fill before sampling
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pwr_r    <= setup_pkg::PWR_SETTLE;
         settle_r <= 2'h0;
         sw_r     <= 8'h00;
      end else begin
         case (pwr_r)
            setup_pkg::PWR_SETTLE: begin
               settle_r <= settle_r + 2'h1;
               if (settle_r == `SETTLE_CYC) begin
                  sw_r  <= sw_sync;
                  pwr_r <= setup_pkg::PWR_RUN;
               end
            end
            setup_pkg::PWR_RUN: begin
               pwr_r <= setup_pkg::PWR_RUN;
            end
            default: begin
               pwr_r <= setup_pkg::PWR_SETTLE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register bus: write side

   logic [31:0] key_mode_r;
   logic [31:0] key_time_r;
   logic        reject_r;
   logic [7:0]  aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0]  w_strb_r;
   logic        wr_go;
   logic [31:0] cand_mode;
   logic [31:0] cand_time;
   logic        cand_ok;
   logic        wr_key;
   logic        wr_status;
   logic        rej_set;
   logic        rej_clr;

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   assign wr_go     = !awready && !wready && !bvalid;
   assign wr_key    = aw_addr_r == `ADDR_KEY_MODE || aw_addr_r == `ADDR_KEY_TIME;
   assign wr_status = aw_addr_r == `ADDR_STATUS;

   always_comb begin
      cand_mode = key_mode_r;
      cand_time = key_time_r;
      if (aw_addr_r == `ADDR_KEY_MODE) begin
         cand_mode = merge(key_mode_r, w_data_r, w_strb_r);
      end
      if (aw_addr_r == `ADDR_KEY_TIME) begin
         cand_time = merge(key_time_r, w_data_r, w_strb_r);
      end
   end

   param_check #(
      .SIX_DIGIT  (SIX_DIGIT),
      .STYLE_MASK (STYLE_MASK)
   ) u_check (
      .dir        (cand_mode[`KM_DIR_LSB +: 3]),
      .style      (cand_mode[`KM_STYLE_LSB +: 4]),
      .stage      (cand_mode[`KM_STAGE_LSB +: 2]),
      .dual_sub   (cand_mode[`KM_SUB_BIT]),
      .t_main     (cand_time[`KT_MAIN_LSB +: 14]),
      .t_one      (cand_time[`KT_ONE_LSB +: 14]),
      .ok         (cand_ok)
   );

   assign rej_set = wr_go && wr_key && !cand_ok;
   assign rej_clr = wr_go && wr_status && w_strb_r[0] && w_data_r[`ST_REJECT_BIT];

   // address and data are taken in either order, answer one edge after both
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= `RESP_OKAY;
         aw_addr_r <= 8'h00;
         w_data_r  <= 32'h0000_0000;
         w_strb_r  <= 4'h0;
      end else begin
         if (awready && awvalid) begin
            awready   <= 1'b0;
            aw_addr_r <= awaddr;
         end
         if (wready && wvalid) begin
            wready   <= 1'b0;
            w_data_r <= wdata;
            w_strb_r <= wstrb;
         end
         if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= (wr_status || (wr_key && cand_ok)) ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // a refused key write keeps the last good set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         key_mode_r <= `KEY_MODE_RST;
         key_time_r <= `KEY_TIME_RST;
      end else if (wr_go && wr_key && cand_ok) begin
         key_mode_r <= cand_mode;
         key_time_r <= cand_time;
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reject_r <= 1'b0;
      end else begin
         reject_r <= rej_set || (reject_r && !rej_clr);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // selection of the governing parameter set

   logic                dip_on;
   logic [2:0]          e_dir;
   setup_pkg::style_t   e_style;
   setup_pkg::style_t   sw_style;
   logic                e_fast;
   logic [13:0]         e_pulse;
   logic                e_rst_short;
   logic                e_src;
   logic [1:0]          e_stage;
   logic [13:0]         e_t1;
   logic                e_two;
   logic                e_s1_style;

   // are the operator's; position 1 alone decides the source
   assign dip_on = sw_r[`SW_ENABLE];

   always_comb begin
      case (sw_r[`SW_STYLE_LSB +: 2])
         2'h0:    sw_style = `STYLE_N;
         2'h1:    sw_style = `STYLE_F;
         2'h2:    sw_style = `STYLE_C;
         2'h3:    sw_style = `STYLE_K1;
         default: sw_style = `STYLE_N;
      endcase
   end

   always_comb begin
      e_stage = key_mode_r[`KM_STAGE_LSB +: 2];
      e_t1    = key_time_r[`KT_ONE_LSB +: 14];
      if (dip_on) begin
         e_fast      = sw_r[`SW_RATE];
         e_dir       = sw_r[`SW_DOWN] ? 3'(setup_pkg::DIR_DOWN)
                                      : 3'(setup_pkg::DIR_UP);
         e_style     = sw_style;
         e_pulse     = sw_r[`SW_PULSE] ? `PULSE_SW_ON : `PULSE_SW_OFF;
         e_rst_short = sw_r[`SW_RST];
         e_src       = sw_r[`SW_SRC];
      end else begin
         e_fast      = key_mode_r[`KM_RATE_BIT];
         e_dir       = key_mode_r[`KM_DIR_LSB +: 3];
         e_style     = key_mode_r[`KM_STYLE_LSB +: 4];
         e_pulse     = key_time_r[`KT_MAIN_LSB +: 14];
         e_rst_short = key_mode_r[`KM_RST_BIT];
         e_src       = key_mode_r[`KM_SRC_BIT];
      end
      e_two      = e_stage == 2'(setup_pkg::STAGE_TWO);
      e_s1_style = e_style >= `STYLE_D && e_style <= `STYLE_H;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered parameter outputs

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         switch_mode         <= 1'b0;
         count_rate_setting  <= 1'b0;
         count_bounce_filter <= 1'b1;
         count_period_cyc    <= 24'(RATE_SLOW_CYC);
      end else begin
         switch_mode         <= dip_on;
         count_rate_setting  <= e_fast;
         count_bounce_filter <= !e_fast;
         count_period_cyc    <= e_fast ? 24'(RATE_FAST_CYC) : 24'(RATE_SLOW_CYC);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_dir <= 3'(setup_pkg::DIR_UP);
         out_style <= `STYLE_N;
      end else begin
         count_dir <= e_dir;
         out_style <= e_style;
      end
   end

   // the pulse time of the single output becomes stage two's in two-stage
   // and batch use; stage one only has its own time under styles 10..12
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oneshot_enable     <= 1'b0;
         pulse_time_cs      <= `PULSE_SW_OFF;
         pulse_on_stage_two <= 1'b0;
         stage_one_pulse_en <= 1'b0;
         stage_one_time_cs  <= `PULSE_LATCH;
         latched_indication <= 1'b0;
      end else begin
         oneshot_enable     <= e_style >= `STYLE_C && e_style <= `STYLE_K2;
         pulse_time_cs      <= e_pulse;
         pulse_on_stage_two <= e_two || e_stage == 2'(setup_pkg::STAGE_BATCH);
         stage_one_pulse_en <= e_two && e_s1_style && e_t1 != `PULSE_LATCH;
         stage_one_time_cs  <= e_t1;
         latched_indication <= e_two && e_s1_style && e_t1 == `PULSE_LATCH;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reset_width_cyc     <= 24'(RST_LONG_CYC);
         reset_bounce_filter <= 1'b1;
         input_sourcing      <= 1'b0;
      end else begin
         reset_width_cyc     <= e_rst_short ? 24'(RST_SHORT_CYC)
                                            : 24'(RST_LONG_CYC);
         reset_bounce_filter <= !e_rst_short;
         input_sourcing      <= e_src;
      end
   end

   // switch styles never reach 09..12, so on 6-digit parts subtraction drops back to sum there
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         stage_cfg <= 2'(setup_pkg::STAGE_ONE);
         dual_sub  <= 1'b0;
      end else begin
         stage_cfg <= e_stage;
         dual_sub  <= key_mode_r[`KM_SUB_BIT]
                      && (!SIX_DIGIT || e_style >= `STYLE_K2);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register bus: read side

   logic [31:0] rd_mux;
   logic        rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      case (araddr)
         `ADDR_STATUS:   rd_mux = {16'h0000, sw_r, 5'h00, latched_indication,
                                   reject_r, dip_on};
         `ADDR_KEY_MODE: rd_mux = key_mode_r;
         `ADDR_KEY_TIME: rd_mux = key_time_r;
         `ADDR_EFFECT:   rd_mux = {15'h0000, 1'b0, stage_one_pulse_en,
                                   oneshot_enable, dual_sub, stage_cfg,
                                   input_sourcing, reset_bounce_filter,
                                   count_rate_setting, out_style, 1'b0, count_dir};
         `ADDR_TIMES:    rd_mux = {2'h0, stage_one_time_cs, 2'h0, pulse_time_cs};
         default: begin
            rd_mux = 32'h0000_0000;
            rd_hit = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `RESP_OKAY;
      end else begin
         if (arready && arvalid) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_mux;
            rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// ==== rtl/setup_cfg.svh ====
// register map, field positions, reset values and timing figures of the setup decoder
// Contract
// - switch settings apply only with position 1 on; otherwise the key set governs
// - switch positions are sampled once after reset; later changes are ignored
// - switches read off until sampled, so key settings govern by default
// - position 2 picks count rate 30 Hz (off, bounce filter) or 5 kHz (on)
// - five count directions; position 3 picks up (off) or down (on)
// - the three up/down count variants come only from the key set
// - twelve output styles 01..12, subset limited by product variant
// - switches reach only output styles 01, 02, 03 and 05
// - pulse time 0.01..99.99 s by keys; position 6 picks 0.5 s or 0.05 s
// - timed pulse exists only for output styles 03 through 09
// - in two-stage or batch use the selected pulse time drives stage two
// - stage-one pulse only for styles 10..12; 0.00 latches; no latch under 09
// - position 7 picks minimum reset width 20 ms (off) or 1 ms (on)
// - dual count combines as sum or first minus second, as selected
// - on 6-digit parts subtraction is allowed only with styles 09..12
// - reset width and chatter filter apply to both reset inputs together
// - position 8 picks sinking (off) or sourcing (on) for all inputs
`ifndef SETUP_CFG_SVH
`define SETUP_CFG_SVH

`define ADDR_STATUS     8'h00
`define ADDR_KEY_MODE   8'h04
`define ADDR_KEY_TIME   8'h08
`define ADDR_EFFECT     8'h0c
`define ADDR_TIMES      8'h10

`define KM_DIR_LSB      0
`define KM_STYLE_LSB    4
`define KM_RATE_BIT     8
`define KM_RST_BIT      9
`define KM_SRC_BIT      10
`define KM_SUB_BIT      11
`define KM_STAGE_LSB    12
`define KT_MAIN_LSB     0
`define KT_ONE_LSB      16
`define ST_REJECT_BIT   1

`define KEY_MODE_RST    32'h0000_0010
`define KEY_TIME_RST    32'h0032_0032

`define SW_ENABLE       0
`define SW_RATE         1
`define SW_DOWN         2
`define SW_STYLE_LSB    3
`define SW_PULSE        5
`define SW_RST          6
`define SW_SRC          7

`define STYLE_N         4'h1
`define STYLE_F         4'h2
`define STYLE_C         4'h3
`define STYLE_K1        4'h5
`define STYLE_K2        4'h9
`define STYLE_D         4'ha
`define STYLE_H         4'hc

`define PULSE_SW_OFF    14'h0032
`define PULSE_SW_ON     14'h0005
`define PULSE_MIN       14'h0001
`define PULSE_MAX       14'h270f
`define PULSE_LATCH     14'h0000

`define CLK_MHZ         250
`define RATE_SLOW_HZ    30
`define RATE_FAST_HZ    5000
`define RST_LONG_MS     20
`define RST_SHORT_MS    1
`define SETTLE_CYC      2'h3

`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== rtl/setup_pkg.sv ====
// types shared by the setup decoder files
package setup_pkg;

   typedef enum logic [2:0] {
      DIR_UP   = 3'h0,
      DIR_DOWN = 3'h1,
      DIR_UDA  = 3'h2,
      DIR_UDB  = 3'h3,
      DIR_UDC  = 3'h4
   } dir_e;

   typedef enum logic [1:0] {
      STAGE_ONE   = 2'h0,
      STAGE_TWO   = 2'h1,
      STAGE_BATCH = 2'h2,
      STAGE_DUAL  = 2'h3
   } stage_e;

   typedef enum logic [0:0] {
      PWR_SETTLE = 1'h0,
      PWR_RUN    = 1'h1
   } pwr_e;

   typedef logic [3:0] style_t;

endpackage

// ==== rtl/pin_sync.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 8
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end

endmodule

`default_nettype wire

// ==== rtl/param_check.sv ====
// mode restriction check of a key-entered parameter set
`timescale 1ns/1ps
`default_nettype none
`include "setup_cfg.svh"

module param_check #(
   parameter bit          SIX_DIGIT  = 1'b1,
   parameter logic [15:0] STYLE_MASK = 16'h1ffe
) (
   input  wire logic [2:0]       dir,
   input  wire setup_pkg::style_t style,
   input  wire logic [1:0]       stage,
   input  wire logic             dual_sub,
   input  wire logic [13:0]      t_main,
   input  wire logic [13:0]      t_one,
   output logic                  ok
);

   logic dir_ok;
   logic style_ok;
   logic time_ok;
   logic hold_ok;
   logic sub_ok;

   always_comb begin
      dir_ok   = dir <= 3'(setup_pkg::DIR_UDC);
      style_ok = STYLE_MASK[style];
      time_ok  = t_main >= `PULSE_MIN && t_main <= `PULSE_MAX
                 && t_one <= `PULSE_MAX;
      hold_ok  = !(stage == 2'(setup_pkg::STAGE_TWO)
                   && t_one == `PULSE_LATCH && style == `STYLE_K2);
      sub_ok   = !(SIX_DIGIT && dual_sub && style < `STYLE_K2);
      ok       = dir_ok && style_ok && time_ok && hold_ok && sub_ok;
   end

endmodule

`default_nettype wire

// ==== test/setup_decode_assertions.sv ====
// concurrent checks on the setup decoder ports
`timescale 1ns/1ps
`default_nettype none
module setup_decode_checker #(
   parameter bit          SIX_DIGIT     = 1'b1,
   parameter int unsigned RATE_SLOW_CYC = 30,
   parameter int unsigned RATE_FAST_CYC = 5,
   parameter int unsigned RST_LONG_CYC  = 20,
   parameter int unsigned RST_SHORT_CYC = 1
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        awready,
   input wire logic        wready,
   input wire logic        bvalid,
   input wire logic        arvalid,
   input wire logic        arready,
   input wire logic        rvalid,
   input wire logic        switch_mode,
   input wire logic        count_rate_setting,
   input wire logic        count_bounce_filter,
   input wire logic [23:0] count_period_cyc,
   input wire logic [2:0]  count_dir,
   input wire logic [3:0]  out_style,
   input wire logic        oneshot_enable,
   input wire logic        latched_indication,
   input wire logic [1:0]  stage_cfg,
   input wire logic [13:0] stage_one_time_cs,
   input wire logic [23:0] reset_width_cyc,
   input wire logic        reset_bounce_filter,
   input wire logic        dual_sub
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   rate_fast_a: assert property (count_rate_setting |->
      count_period_cyc == 24'(RATE_FAST_CYC) && !count_bounce_filter) else $error("fast rate");
   rate_slow_a: assert property (!count_rate_setting |->
      count_period_cyc == 24'(RATE_SLOW_CYC) && count_bounce_filter) else $error("slow rate");
   reset_width_a: assert property (reset_width_cyc ==
      (reset_bounce_filter ? 24'(RST_LONG_CYC) : 24'(RST_SHORT_CYC))) else $error("reset width");
   oneshot_style_a: assert property (oneshot_enable ==
      (out_style >= 4'h3 && out_style <= 4'h9)) else $error("one-shot style");
   latch_stage_a: assert property (latched_indication |-> stage_cfg == 2'h1 &&
      out_style >= 4'ha && stage_one_time_cs == 14'h0) else $error("latch cond");
   sub_gate_a: assert property (SIX_DIGIT && dual_sub |-> out_style >= 4'h9)
      else $error("sub style");
   switch_style_a: assert property (switch_mode |->
      out_style inside {4'h1, 4'h2, 4'h3, 4'h5} && count_dir <= 3'h1) else $error("switch style");
   switch_hold_a: assert property (switch_mode && $past(switch_mode) |-> $stable(out_style)
      && $stable(count_dir)) else $error("switch moved");
   dir_range_a: assert property (count_dir <= 3'h4) else $error("dir range");
   write_busy_a: assert property ($rose(bvalid) |-> !awready && !wready)
      else $error("write busy");
   read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer");
endmodule
bind preset_counter_setup_decode setup_decode_checker #(.SIX_DIGIT(SIX_DIGIT),
   .RATE_SLOW_CYC(RATE_SLOW_CYC), .RATE_FAST_CYC(RATE_FAST_CYC),
   .RST_LONG_CYC(RST_LONG_CYC), .RST_SHORT_CYC(RST_SHORT_CYC)) chk_i (.*);
`default_nettype wire

// ==== test/operator_panel.sv ====
// operator side: switch bank held steady across power-on
`timescale 1ns/1ps
`default_nettype none
module operator_panel (
   input  wire logic       aclk,
   input  wire logic [7:0] want_sw,
   input  wire logic       key_entry,
   input  wire logic       contacts,
   output var  logic [7:0] dip_sw
);
   always @(posedge aclk) begin
      dip_sw <= {want_sw[7:2], want_sw[1] & ~contacts, want_sw[0] & ~key_entry};
   end
endmodule
`default_nettype wire

// ==== test/preset_counter_setup_decode_bench.sv ====
// self-checking bench of the setup decoder
`timescale 1ns/1ps
`default_nettype none
`include "setup_cfg.svh"
module preset_counter_setup_decode_bench;
   logic        aclk = 1'b0, aresetn = 1'b0, key_entry = 1'b1, contacts = 1'b0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]  want_sw = 8'h00, awaddr = 8'h00, araddr = 8'h00, dip_sw;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, r, stage_cfg;
   logic        awready, wready, bvalid, arready, rvalid, switch_mode, count_rate_setting;
   logic        count_bounce_filter, oneshot_enable, pulse_on_stage_two, stage_one_pulse_en;
   logic        latched_indication, reset_bounce_filter, input_sourcing, dual_sub;
   logic [23:0] count_period_cyc, reset_width_cyc;
   logic [13:0] pulse_time_cs, stage_one_time_cs;
   logic [2:0]  count_dir;
   logic [3:0]  out_style;
   int          error_cnt = 0, n_tests = 0;
   // short counts keep the expected values small; only output values depend on them
   preset_counter_setup_decode #(.RATE_SLOW_CYC(30), .RATE_FAST_CYC(5),
      .RST_LONG_CYC(20), .RST_SHORT_CYC(1)) preset_counter_setup_decode_i (.*,
      .awprot(3'h0), .arprot(3'h0));
   operator_panel operator_panel_i (.*);
   always #2 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("mismatches %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic hung();
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, 1'b0, 1'b1);
      finish_test();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            repeat (2) @(posedge aclk);
            return;
         end
      end
      hung();
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            return;
         end
      end
      hung();
   endtask
   task automatic power_up(input logic [7:0] sw);
      @(posedge aclk);
      aresetn <= 1'b0;
      want_sw <= sw;
      key_entry <= ~sw[0];
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic switch_set();
      logic [7:0] sw;
      logic [3:0] tab [4] = '{4'h1, 4'h2, 4'h3, 4'h5};
      power_up(8'h00);
      rd(`ADDR_STATUS);
      chk(d & 32'h0000_ff01, 32'h0);
      for (int i = 0; i < 4; i++) begin
         sw = {i[0], i[1], ~i[0], i[1:0], i[0], i[1] | i[0], 1'b1};
         contacts <= (i == 3);
         power_up(sw);
         chk(switch_mode, 1'b1);
         chk(count_rate_setting, sw[1] & (i != 3));
         chk(count_dir, sw[2]);
         chk(out_style, tab[i]);
         chk(pulse_time_cs, sw[5] ? 14'h0005 : 14'h0032);
         chk(reset_width_cyc, sw[6] ? 24'h1 : 24'h14);
         chk(input_sourcing, sw[7]);
         want_sw <= ~sw;
         wr(`ADDR_KEY_MODE, 32'h0000_0072);
         chk({out_style, count_dir}, {tab[i], 2'h0, sw[2]});
      end
      contacts <= 1'b0;
      power_up(8'hfe);
      chk(switch_mode, 1'b0);
      chk({out_style, count_dir, pulse_time_cs}, {4'h1, 3'h0, 14'h0032});
   endtask
   task automatic key_set();
      logic [31:0] bad [7] = '{32'h15, 32'h0, 32'hd0, 32'h3850, 32'h1090, 32'h0, 32'h2710};
      for (int s = 1; s <= 12; s++) begin
         wr(`ADDR_KEY_MODE, 32'(s << 4) | 32'(s % 5) | 32'((s & 1) << 8));
         chk(r, `RESP_OKAY);
         chk({count_dir, out_style}, {3'(s % 5), 4'(s)});
         chk(oneshot_enable, s >= 3 && s <= 9);
         chk(count_period_cyc, (s & 1) ? 24'h5 : 24'h1e);
      end
      wr(`ADDR_KEY_TIME, 32'h0000_0032);
      wr(`ADDR_KEY_MODE, 32'h0000_0030);
      for (int k = 0; k < 7; k++) begin
         wr(k < 5 ? `ADDR_KEY_MODE : `ADDR_KEY_TIME, bad[k]);
         chk(r, `RESP_SLVERR);
      end
      rd(`ADDR_KEY_MODE);
      chk(d, 32'h0000_0030);
      rd(`ADDR_STATUS);
      chk(d[1], 1'b1);
      wr(`ADDR_KEY_MODE, 32'h0000_10a0);
      chk({latched_indication, pulse_on_stage_two, stage_one_pulse_en}, 3'h6);
      wr(`ADDR_KEY_TIME, 32'h0064_0032);
      chk({latched_indication, stage_one_pulse_en, stage_one_time_cs}, {2'h1, 14'h64});
      wr(`ADDR_KEY_MODE, 32'h0000_3890);
      chk({r, dual_sub}, {`RESP_OKAY, 1'b1});
      rd(`ADDR_EFFECT);
      chk(d, 32'h0000_7a90);
      rd(`ADDR_TIMES);
      chk(d, 32'h0064_0032);
      // lane 0 only: upper bytes of the data must not land
      wstrb <= 4'h1;
      wr(`ADDR_KEY_MODE, 32'hffff_ffa0);
      wr(`ADDR_STATUS, 32'h0000_0002);
      wstrb <= 4'hf;
      rd(`ADDR_KEY_MODE);
      chk(d, 32'h0000_38a0);
      rd(`ADDR_STATUS);
      chk(d[1], 1'b0);
      wr(8'h14, 32'h1);
      chk(r, `RESP_SLVERR);
      rd(8'h14);
      chk({r, d}, {`RESP_SLVERR, 32'h0});
   endtask
   initial begin
      switch_set();
      power_up(8'h00);
      key_set();
      finish_test();
   end
endmodule
`default_nettype wire
